//--- rtl/speed_loop_settings.sv
// speed loop settings: feedback scaling, reference sum, filter, gains
// Behaviour
// - armature feedback scaled so maximum armature voltage gives full scale
// - under encoder or tacho feedback clamp when armature magnitude exceeds the clamp threshold
// - clamp threshold is maximum armature voltage times 1.2
// - maximum armature voltage resets to 485 V Europe, 550 V US
// - rpm display scaled by rpm setting: feedback times setting over 1000
// - IR compensation equals error integral times IR gain over 2048 under armature feedback, zero otherwise
// - signed hard reference of +-1000 bypasses the ramp
// - hard reference added only when select and reference-on both one
// - ramp output added while ramp select is one, default one
// - droop under armature feedback lowers speed as load rises
// - fine offset 0..255 maps linearly to -8..+8, 128 gives zero
// - zero-speed threshold 0..255 default 16, 0.1 percent per count
// - derivative source 1 error, 2 final demand, 3 feedback, default 1
// - speed error low-pass with constant 256 over 6f times setting
// - read-only tacho monitor, signed, 1000 at full speed
// - gain-times-four bit multiplies proportional gain by four
// - reduction bit divides both gains by eight
// - encoder if select one, else armature if type one, else tacho
// - error integral integrates filtered error, feeds IR compensation
`default_nettype none
module speed_loop_settings #(
  parameter int TICK = speed_loop_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // settings and control bits
  input wire speed_loop_pkg::ctl_bits_t ctl,
  input wire speed_loop_pkg::settings_t cfg,
  // measured and reference values, +-1000 scale except armVolts, which is in volts
  input wire logic signed [11:0] armVolts,
  input wire logic signed [11:0] tachoIn,
  input wire logic signed [11:0] encoderSpeed,
  input wire logic signed [11:0] rampOut,
  input wire logic signed [11:0] hardRef,
  // results
  output logic signed [11:0] finalDemand,
  output logic signed [11:0] speedFb,
  output logic signed [15:0] speedRpm,
  output logic signed [11:0] speedErr,
  output logic signed [11:0] errIntegral,
  output logic signed [11:0] irCompOut,
  output logic signed [11:0] tachoMon,
  output logic signed [11:0] derivInput,
  output logic [15:0] prop_gain_effective,
  output logic [15:0] integ_gain_effective,
  output logic armClamp,
  output logic zeroSpeed,
  output logic [10:0] armMaxNow,
  output logic [1:0] derivSrcNow
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic signed [11:0] sat12(input logic signed [23:0] v);
    if (v > 24'sd1000) return 12'sd1000;
    if (v < -24'sd1000) return -12'sd1000;
    return v[11:0];
  endfunction

  // ------------------------------------------------------------
  // held settings and loop state
  // ------------------------------------------------------------
  logic [10:0] armMax_q, armMax_d;
  logic [1:0] derivSrc_q, derivSrc_d;
  logic signed [23:0] filt_q, filt_d;
  logic signed [23:0] integ_q, integ_d;
  logic [23:0] tick_q, tick_d;
  logic signed [11:0] demand_q, fb_q, err_q, tacho_q, ir_q, deriv_q;
  logic signed [15:0] rpm_q;
  logic clamp_q, zero_q;

  wire logic [10:0] armDefault = ctl.euVariant ? speed_loop_pkg::ARM_MAX_EU
                                               : speed_loop_pkg::ARM_MAX_US;
  wire logic armWrOk = cfg.armMaxWr &&
                       cfg.armMax <= speed_loop_pkg::ARM_MAX_LIMIT;
  wire logic derivOk = cfg.derivWr && cfg.derivSrc != 2'h0;
  wire logic tick = tick_q == 24'(TICK - 1);
  wire logic avfUsed = !ctl.encSel && ctl.avfSel;

  // ------------------------------------------------------------
  // feedback selection and scaling
  // ------------------------------------------------------------
  wire logic signed [23:0] armScaled = (armMax_q == 11'h000) ? 24'sd0 :
    24'((32'(armVolts) * 32'sd1000) / 32'($signed({1'b0, armMax_q})));
  wire logic signed [11:0] fbSel = ctl.encSel ? encoderSpeed :
    (ctl.avfSel ? sat12(armScaled) : tachoIn);
  wire logic [15:0] clampLvl =
    16'((32'(armMax_q) * speed_loop_pkg::CLAMP_NUM)
        / speed_loop_pkg::CLAMP_DEN);
  wire logic signed [12:0] armAbs = armVolts < 0 ? -13'(armVolts)
                                                 : 13'(armVolts);
  wire logic clampNow = !avfUsed && 16'(armAbs) > clampLvl;

  // ------------------------------------------------------------
  // reference summation
  // ------------------------------------------------------------
  // rounded to nearest so that both ends reach a full eight units
  wire logic signed [15:0] fineScaled =
    16'(($signed({4'h0, cfg.fineOffset}) - 12'sd128) * 16);
  wire logic signed [15:0] fineBias = fineScaled < 0 ? -16'sd127
                                                     : 16'sd127;
  wire logic signed [11:0] fineTrim =
    12'((fineScaled + fineBias) / 16'sd255);
  wire logic signed [23:0] droopTerm = (avfUsed && ctl.droopSel)
    ? -24'(ir_q) : 24'sd0;
  wire logic signed [23:0] sumRef = 24'(ctl.rampSel ? rampOut : 12'sd0)
    + 24'((ctl.hardSel && ctl.refOn) ? hardRef : 12'sd0)
    + 24'(fineTrim) + droopTerm;
  wire logic signed [11:0] demandNext = sat12(sumRef);

  // ------------------------------------------------------------
  // error filter, integral, IR compensation
  // ------------------------------------------------------------
  wire logic signed [23:0] rawErr = 24'(demand_q) - 24'(fb_q);
  wire logic signed [23:0] filtOut = filt_q >>> speed_loop_pkg::FILT_SHIFT;
  wire logic signed [23:0] filtStep =
    ((rawErr - filtOut) * $signed({16'h0, cfg.filterSet}));
  wire logic signed [23:0] integStep =
    24'((filtOut * $signed({16'h0, integ_gain_effective})) >>> 8);
  wire logic signed [23:0] irNext =
    (integ_q * $signed({16'h0, cfg.irGain})) >>> speed_loop_pkg::IR_SHIFT;

  // ------------------------------------------------------------
  // rpm, gains, zero speed, derivative source
  // ------------------------------------------------------------
  wire logic signed [31:0] rpmRaw =
    (32'(fb_q) * $signed({21'h0, cfg.rpmScale})) / 32'sd1000;
  wire logic [15:0] pBase = {8'h00, cfg.propGain} <<
    (ctl.gainX4 ? speed_loop_pkg::PROP_X4_SHIFT : 0);
  wire logic [15:0] iBase = {8'h00, cfg.integGain};
  wire logic [11:0] zeroLvl = {4'h0, cfg.zeroThr};
  wire logic signed [11:0] fbAbs = fb_q < 0 ? -fb_q : fb_q;
  wire logic signed [11:0] derivNext =
    derivSrc_q == speed_loop_pkg::DERIV_DEMAND ? demand_q :
    derivSrc_q == speed_loop_pkg::DERIV_FB ? fb_q : err_q;

  assign prop_gain_effective = ctl.gainDiv8
    ? pBase >> speed_loop_pkg::REDUCE_SHIFT : pBase;
  assign integ_gain_effective = ctl.gainDiv8
    ? iBase >> speed_loop_pkg::REDUCE_SHIFT : iBase;

  always_comb begin
    armMax_d = armWrOk ? cfg.armMax : armMax_q;
    derivSrc_d = derivOk ? cfg.derivSrc : derivSrc_q;
    tick_d = tick ? 24'h00_0000 : tick_q + 24'h00_0001;
    filt_d = tick ? filt_q + filtStep : filt_q;
    integ_d = integ_q;
    if (tick) begin
      integ_d = integ_q + integStep;
      if (integ_d > 24'sd256000) integ_d = 24'sd256000;
      if (integ_d < -24'sd256000) integ_d = -24'sd256000;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      armMax_q <= armDefault;
      derivSrc_q <= speed_loop_pkg::DERIV_ERR;
      tick_q <= '0;
      filt_q <= '0;
      integ_q <= '0;
      demand_q <= '0;
      fb_q <= '0;
      err_q <= '0;
      tacho_q <= '0;
      ir_q <= '0;
      deriv_q <= '0;
      rpm_q <= '0;
      clamp_q <= 1'b0;
      zero_q <= 1'b1;
    end else begin
      armMax_q <= armMax_d;
      derivSrc_q <= derivSrc_d;
      tick_q <= tick_d;
      filt_q <= filt_d;
      integ_q <= integ_d;
      demand_q <= demandNext;
      fb_q <= fbSel;
      err_q <= sat12(filtOut);
      tacho_q <= tachoIn;
      ir_q <= avfUsed ? sat12(irNext) : 12'sd0;
      deriv_q <= derivNext;
      rpm_q <= rpmRaw[15:0];
      clamp_q <= clampNow;
      zero_q <= 12'(fbAbs) <= zeroLvl;
    end
  end

  assign finalDemand = demand_q;
  assign speedFb = fb_q;
  assign speedRpm = rpm_q;
  assign speedErr = err_q;
  assign errIntegral = sat12(integ_q >>> 8);
  assign irCompOut = ir_q;
  assign tachoMon = tacho_q;
  assign derivInput = deriv_q;
  assign armClamp = clamp_q;
  assign zeroSpeed = zero_q;
  assign armMaxNow = armMax_q;
  assign derivSrcNow = derivSrc_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  deriv_src_legal_a: assert property (derivSrcNow != 2'h0)
    else $error("derivative source left the legal set");
  deriv_bad_write_a: assert property (
    cfg.derivWr && cfg.derivSrc == 2'h0 |=> $stable(derivSrcNow))
    else $error("illegal derivative source write took effect");
  clamp_avf_off_a: assert property (avfUsed |=> !armClamp)
    else $error("clamp active under armature feedback");
  clamp_level_a: assert property (
    !avfUsed && 16'(armAbs) > clampLvl |=> armClamp)
    else $error("clamp missed above threshold");
  ir_zero_tacho_a: assert property (!avfUsed |=> irCompOut == 0)
    else $error("IR compensation without armature feedback");
  fb_encoder_a: assert property (
    ctl.encSel |=> speedFb == $past(encoderSpeed))
    else $error("encoder feedback not selected");
  tacho_follow_a: assert property (##1 tachoMon == $past(tachoIn))
    else $error("tacho monitor stale");
  gain_reduce_a: assert property (
    ctl.gainDiv8 && !ctl.gainX4 |->
      prop_gain_effective == 16'(cfg.propGain >> 3))
    else $error("proportional gain not reduced");
  hard_only_a: assert property (
    ctl.hardSel && ctl.refOn && !ctl.rampSel && !ctl.droopSel &&
      cfg.fineOffset == speed_loop_pkg::OFFSET_DEF &&
      hardRef inside {[-12'sd1000:12'sd1000]}
      |=> finalDemand == $past(hardRef))
    else $error("hard reference not passed to summation");

  hard_ref_c: cover property (ctl.hardSel && ctl.refOn);
  clamp_hit_c: cover property (armClamp);
  avf_droop_c: cover property (avfUsed && ctl.droopSel && irCompOut != 0);
endmodule
`default_nettype wire

//--- rtl/speed_loop_pkg.sv
// package: constants and carriers for the speed loop settings block
`default_nettype none
package speed_loop_pkg;
  localparam int VAL_W = 12;
  localparam logic [10:0] ARM_MAX_EU = 11'h1E5;
  localparam logic [10:0] ARM_MAX_US = 11'h226;
  localparam logic [10:0] ARM_MAX_LIMIT = 11'h3E8;
  localparam logic signed [11:0] FULL_SCALE = 12'sh3E8;
  localparam logic [10:0] RPM_DECADE_LIMIT = 11'h7CF;
  localparam int IR_SHIFT = 11;
  localparam logic [7:0] OFFSET_DEF = 8'h80;
  localparam logic [7:0] ZERO_THR_DEF = 8'h10;
  localparam logic [7:0] FILTER_DEF = 8'h10;
  localparam logic [7:0] PROP_GAIN_EFFECTIVE_DEF = 8'h50;
  localparam logic [7:0] INTEG_GAIN_EFFECTIVE_DEF = 8'h28;
  localparam logic [7:0] IRCOMP_DEF = 8'h00;
  localparam logic [10:0] RPM_DEF = 11'h6D6;
  localparam int FILT_SHIFT = 8;
  localparam int PROP_SHIFT = 3;
  localparam int PROP_X4_SHIFT = 2;
  localparam int REDUCE_SHIFT = 3;
  localparam int CLAMP_NUM = 6;
  localparam int CLAMP_DEN = 5;
  localparam logic signed [11:0] FINE_SPAN = 12'sh008;
  localparam int MAINS_TICK_NS = 3333333;
  localparam int CLK_NS = 20;
  localparam int TICK_CYCLES = MAINS_TICK_NS / CLK_NS;

  typedef enum logic [1:0] {
    DERIV_ERR = 2'h1,
    DERIV_DEMAND = 2'h2,
    DERIV_FB = 2'h3
  } deriv_src_t;

  typedef struct packed {
    logic encSel;
    logic avfSel;
    logic hardSel;
    logic refOn;
    logic rampSel;
    logic droopSel;
    logic gainX4;
    logic gainDiv8;
    logic euVariant;
  } ctl_bits_t;

  typedef struct packed {
    logic [10:0] armMax;
    logic [10:0] rpmScale;
    logic [7:0] irGain;
    logic [7:0] fineOffset;
    logic [7:0] zeroThr;
    logic [7:0] filterSet;
    logic [7:0] propGain;
    logic [7:0] integGain;
    logic [1:0] derivSrc;
    logic derivWr;
    logic armMaxWr;
  } settings_t;
endpackage
`default_nettype wire

//--- testbench/speed_transducers.sv
// transducer model: armature, tacho and encoder readings of the motor
`default_nettype none
module speed_transducers (
  // clock
  input wire logic mclk,
  // commanded motor state
  input wire logic signed [11:0] motorSpeed,
  input wire logic signed [11:0] motorVolts,
  // transducer readings
  output logic signed [11:0] armVolts,
  output logic signed [11:0] tachoIn,
  output logic signed [11:0] encoderSpeed
);
  timeunit 1ns;
  timeprecision 1ps;
  // tacho pot trimmed to half so tacho and encoder readings differ
  always_ff @(posedge mclk) begin
    armVolts <= motorVolts;
    tachoIn <= motorSpeed >>> 1;
    encoderSpeed <= motorSpeed;
  end
endmodule
`default_nettype wire

//--- testbench/dc_drive_speed_loop_settings_tb.sv
// testbench: speed loop settings against a transducer model
`default_nettype none
module dc_drive_speed_loop_settings_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  speed_loop_pkg::ctl_bits_t ctl;
  speed_loop_pkg::settings_t cfg;
  logic signed [11:0] motorSpeed, motorVolts, rampOut, hardRef;
  logic signed [11:0] armV, tachoV, encV, finalDemand, speedFb;
  logic signed [11:0] tachoMon, derivInput, speedErr, errIntegral, irComp;
  logic [15:0] propEff, integEff;
  logic signed [15:0] speedRpm;
  logic armClamp, zeroSpeed;
  logic [10:0] armMaxNow;
  logic [1:0] derivSrcNow;
  int mismatches = 0;
  int tests_run = 0;

  initial begin
    forever #10 mclk = ~mclk;
  end

  speed_transducers u_xdcr (.mclk(mclk), .motorSpeed(motorSpeed),
    .motorVolts(motorVolts), .armVolts(armV), .tachoIn(tachoV),
    .encoderSpeed(encV));

  speed_loop_settings #(.TICK(4)) u_dut (.mclk(mclk), .reset(reset),
    .ctl(ctl), .cfg(cfg), .armVolts(armV), .tachoIn(tachoV),
    .encoderSpeed(encV), .rampOut(rampOut), .hardRef(hardRef),
    .finalDemand(finalDemand), .speedFb(speedFb), .speedRpm(speedRpm),
    .speedErr(speedErr), .errIntegral(errIntegral), .irCompOut(irComp),
    .tachoMon(tachoMon), .derivInput(derivInput),
    .prop_gain_effective(propEff), .integ_gain_effective(integEff),
    .armClamp(armClamp), .zeroSpeed(zeroSpeed),
    .armMaxNow(armMaxNow), .derivSrcNow(derivSrcNow));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wrArm(input logic [10:0] v);
    cfg.armMax = v;
    cfg.armMaxWr = 1'b1;
    step(1);
    cfg.armMaxWr = 1'b0;
    step(2);
  endtask

  task automatic wrDeriv(input logic [1:0] v);
    cfg.derivSrc = v;
    cfg.derivWr = 1'b1;
    step(1);
    cfg.derivWr = 1'b0;
    step(2);
  endtask

  task automatic motor(input logic [11:0] s, input logic [11:0] v);
    motorSpeed = s;
    motorVolts = v;
    step(5);
  endtask

  task automatic demand(input logic [11:0] r, input logic [11:0] h,
      input logic [2:0] sel, input logic [7:0] fo, input logic [11:0] e);
    rampOut = r;
    hardRef = h;
    {ctl.hardSel, ctl.refOn, ctl.rampSel} = sel;
    cfg.fineOffset = fo;
    step(4);
    check(finalDemand, {{4{e[11]}}, e});
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  initial begin
    ctl = '0;
    ctl.rampSel = 1'b1;
    ctl.euVariant = 1'b1;
    cfg = '0;
    cfg.fineOffset = 8'h80;
    cfg.zeroThr = 8'h10;
    cfg.filterSet = 8'h10;
    cfg.rpmScale = 11'h5DC;
    cfg.derivSrc = 2'h1;
    {motorSpeed, motorVolts, rampOut, hardRef} = '0;
    step(20);
    reset = 1'b0;
    step(1);
    check(armMaxNow, 16'h01E5);
    check(derivSrcNow, 16'h0001);
    check(zeroSpeed, 16'h0001);
    $display("test reset done");
    wrArm(11'h3E9);
    check(armMaxNow, 16'h01E5);
    wrArm(11'h1F4);
    check(armMaxNow, 16'h01F4);
    wrDeriv(2'h0);
    check(derivSrcNow, 16'h0001);
    $display("test settings writes done");
    ctl.encSel = 1'b1;
    motor(12'sh064, 12'sh0FA);
    check(speedFb, 16'h0064);
    ctl.encSel = 1'b0;
    motor(12'sh064, 12'sh0FA);
    check(speedFb, 16'h0032);
    wrDeriv(2'h3);
    check(derivSrcNow, 16'h0003);
    check(derivInput, 16'h0032);
    ctl.avfSel = 1'b1;
    motor(12'sh064, 12'sh0FA);
    check(speedFb, 16'h01F4);
    check(speedRpm, 16'h02EE);
    ctl.avfSel = 1'b0;
    motor(12'sh020, 12'sh000);
    check(zeroSpeed, 16'h0001);
    motor(12'sh022, 12'sh000);
    check(zeroSpeed, 16'h0000);
    motor(12'sh7D0, 12'sh000);
    check(tachoMon, 16'h03E8);
    ctl.encSel = 1'b1;
    motor(12'sh100, 12'sh259);
    check(armClamp, 16'h0001);
    motor(12'sh100, 12'sh258);
    check(armClamp, 16'h0000);
    $display("test feedback done");
    demand(12'sh12C, 12'shF9C, 3'h7, 8'h80, 12'sh0C8);
    demand(12'sh12C, 12'shF9C, 3'h5, 8'h80, 12'sh12C);
    demand(12'sh12C, 12'shF9C, 3'h6, 8'h80, 12'shF9C);
    demand(12'sh3E8, 12'sh3E8, 3'h7, 8'h80, 12'sh3E8);
    demand(12'sh12C, 12'sh000, 3'h1, 8'hFF, 12'sh134);
    demand(12'sh12C, 12'sh000, 3'h1, 8'h00, 12'sh124);
    $display("test demand done");
    cfg.propGain = 8'h50;
    cfg.integGain = 8'h28;
    ctl.gainX4 = 1'b1;
    step(1);
    check(propEff, 16'h0140);
    ctl.gainDiv8 = 1'b1;
    step(1);
    check(propEff, 16'h0028);
    check(integEff, 16'h0005);
    ctl.gainX4 = 1'b0;
    ctl.gainDiv8 = 1'b0;
    step(1);
    check(propEff, 16'h0050);
    $display("test gains done");
    ctl.encSel = 1'b0;
    ctl.avfSel = 1'b1;
    cfg.irGain = 8'h80;
    motor(12'sh000, 12'sh000);
    step(200);
    check(speedErr > 12'sd0, 16'h0001);
    check(errIntegral > 12'sd0, 16'h0001);
    check(irComp > 12'sd0, 16'h0001);
    ctl.droopSel = 1'b1;
    step(4);
    check(finalDemand < 12'sh124, 16'h0001);
    ctl.avfSel = 1'b0;
    step(3);
    check(irComp == 12'sd0, 16'h0001);
    check(finalDemand, 16'h0124);
    $display("test integral done");
    ctl.euVariant = 1'b0;
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    step(1);
    check(armMaxNow, 16'h0226);
    check(derivSrcNow, 16'h0001);
    $display("test second reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
